// ===== pkg/fslc_pkg.sv
// Shared constants and types of the flash sector lock controller
package fslc_pkg;
	// Lock byte value and tolerance
	localparam logic [7:0] LOCK_ON = 8'h69;
	localparam logic [7:0] LOCK_OFF = 8'h00;
	localparam logic [3:0] LOCK_TOL = 4'h3;
	localparam int NUM_LOCK = 3;
	// Index of each lock byte, also its rank (0 is the highest)
	localparam logic [1:0] LK_EXT = 2'h0;
	localparam logic [1:0] LK_CODE = 2'h1;
	localparam logic [1:0] LK_CFG = 2'h2;
	// Sector codes on the access port
	localparam logic [1:0] SEC_EXT = 2'h0;
	localparam logic [1:0] SEC_CODE = 2'h1;
	localparam logic [1:0] SEC_CFG = 2'h2;
	localparam logic [1:0] SEC_ROM = 2'h3;
	// Flash map: sector bases and sizes, lock byte is the last byte of each sector
	localparam int FL_AW = 16;
	localparam logic [15:0] CODE_BASE = 16'h0000;
	localparam logic [15:0] CODE_SIZE = 16'h3000;
	localparam logic [15:0] EXT_BASE = 16'h3000;
	localparam logic [15:0] EXT_SIZE = 16'h0800;
	localparam logic [15:0] CFG_BASE = 16'h3800;
	localparam logic [15:0] CFG_SIZE = 16'h0100;
	localparam logic [15:0] EXT_LOCK_ADDR = EXT_BASE + EXT_SIZE - 16'h0001;
	localparam logic [15:0] CODE_LOCK_ADDR = CODE_BASE + CODE_SIZE - 16'h0001;
	localparam logic [15:0] CFG_LOCK_ADDR = CFG_BASE + CFG_SIZE - 16'h0001;
	localparam logic [2:0][15:0] LOCK_ADDR = {CFG_LOCK_ADDR, CODE_LOCK_ADDR, EXT_LOCK_ADDR};
	// Register byte offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_RAW = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	// Status fields
	localparam int ST_READY = 0;
	localparam int ST_EFF_LSB = 1;
	localparam int ST_DEBUG_OK = 4;
	localparam int ST_PROG = 5;
	localparam int ST_BUSY = 6;
	// Command fields
	localparam int CMD_SET_CFG_LOCK = 0;
	localparam int CMD_ERASE_ALL = 1;
	localparam int CMD_POWER_OFF = 2;
	// Access operations
	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_ERASE,
		OP_ERASE_ALL
	} fslc_op_type;
endpackage

// ===== pkg/fslc_perm_if.sv
// Effective lock flags passed from the evaluator to the access checker
`timescale 1ns/100ps
interface fslc_perm_if;
	logic ready;
	logic [2:0] eff;
	modport src(output eff);
	modport sink(input ready, input eff);
	modport top_side(output ready, input eff);
endinterface // fslc_perm_if

// ===== hw/fslc_lock_eval.sv
// Tolerance check and rank chain over the three loaded lock bytes
`timescale 1ns/100ps
module fslc_lock_eval (
	input wire logic [fslc_pkg::NUM_LOCK-1:0][7:0] lock_bytes,
	fslc_perm_if.src perm
);
	import fslc_pkg::*;

	logic [NUM_LOCK-1:0] byte_on;
	logic [NUM_LOCK-1:0] chain;

	genvar i;
	generate
		for (i = 0; i < NUM_LOCK; i++) begin : g_lock
			assign byte_on[i] = 4'($countones(lock_bytes[i] ^ LOCK_ON)) <= LOCK_TOL;
			if (i == 0) begin : g_top
				assign chain[i] = byte_on[i];
			end else begin : g_low
				assign chain[i] = chain[i-1] & byte_on[i];
			end
		end
	endgenerate

	assign perm.eff = chain;
endmodule // fslc_lock_eval

// ===== hw/fslc_access_check.sv
// Read, write and erase permission for one access request
`timescale 1ns/100ps
module fslc_access_check (
	fslc_perm_if.sink perm,
	input wire logic prog,
	input wire logic [1:0] sector,
	input wire fslc_pkg::fslc_op_type op,
	input wire logic from_ext,
	output logic grant
);
	import fslc_pkg::*;

	logic locked;

	always_comb begin
		case (sector)
			SEC_EXT: locked = perm.eff[LK_EXT];
			SEC_CODE: locked = perm.eff[LK_CODE];
			SEC_CFG: locked = perm.eff[LK_CFG];
			default: locked = 1'b1;
		endcase
	end

	always_comb begin
		grant = 1'b0;
		if (!perm.ready) begin
			grant = 1'b0;
		end else if (prog) begin
			if (op == OP_ERASE_ALL) begin
				grant = 1'b1;
			end else begin
				grant = (sector != SEC_ROM) && !locked;
			end
		end else begin
			case (op)
				OP_READ: grant = (sector != SEC_ROM);
				OP_WRITE: begin
					case (sector)
						SEC_CODE: grant = !perm.eff[LK_CODE] || from_ext;
						SEC_CFG: grant = 1'b1;
						default: grant = 1'b0;
					endcase
				end
				OP_ERASE: grant = (sector == SEC_CODE) || (sector == SEC_CFG);
				default: grant = 1'b0;
			endcase
		end
	end
endmodule // fslc_access_check

// ===== hw/fslc_top.sv
// Flash sector lock controller: lock byte load, permissions and register slave
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module fslc_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic prog_mode_pin,
	input wire logic debug_req_pin,
	output logic debug_enable,
	output logic fl_rd_req,
	output logic [fslc_pkg::FL_AW-1:0] fl_rd_addr,
	input wire logic [7:0] fl_rd_data,
	input wire logic fl_rd_valid,
	output logic fl_wr_req,
	output logic [fslc_pkg::FL_AW-1:0] fl_wr_addr,
	output logic [7:0] fl_wr_data,
	output logic fl_erase_all_req,
	input wire logic fl_op_ack,
	output logic flash_power_off_command,
	input wire logic acc_valid,
	input wire logic [1:0] acc_sector,
	input wire fslc_pkg::fslc_op_type acc_op,
	input wire logic acc_from_ext,
	output logic acc_done,
	output logic acc_grant
);
	import fslc_pkg::*;

	typedef enum {
		FS_LOAD,
		FS_READY,
		FS_LOCK_WR,
		FS_ERASE
	} fslc_state_type;

	fslc_state_type state_reg;
	logic [1:0] rst_pipe_reg;
	logic rst_n;
	logic [2:0] prog_sync_reg;
	logic [2:0] dbg_sync_reg;
	logic prog_reg;
	logic dbg_reg;
	logic [NUM_LOCK-1:0][7:0] lock_raw_reg;
	logic [1:0] load_idx_reg;
	logic [1:0] load_idx_next;
	logic load_hit;
	logic load_last;
	logic rd_req_reg;
	logic [FL_AW-1:0] rd_addr_reg;
	logic wr_req_reg;
	logic [FL_AW-1:0] wr_addr_reg;
	logic [7:0] wr_data_reg;
	logic erase_reg;
	logic pwr_off_reg;
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic cmd_write;
	logic cmd_set_lock;
	logic cmd_erase_all;
	logic grant_c;
	logic done_reg;
	logic grant_reg;
	logic debug_reg;

	fslc_perm_if perm ();

	//////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe_reg[1];

	// A change is taken only once the second and third stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_sync_reg <= 3'h0;
			dbg_sync_reg <= 3'h0;
			prog_reg <= 1'b0;
			dbg_reg <= 1'b0;
		end else begin
			prog_sync_reg <= {prog_sync_reg[1:0], prog_mode_pin};
			dbg_sync_reg <= {dbg_sync_reg[1:0], debug_req_pin};
			if (prog_sync_reg[1] == prog_sync_reg[2]) begin
				prog_reg <= prog_sync_reg[2];
			end
			if (dbg_sync_reg[1] == dbg_sync_reg[2]) begin
				dbg_reg <= dbg_sync_reg[2];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Lock byte load after reset

	assign load_hit = (state_reg == FS_LOAD) && rd_req_reg && fl_rd_valid;
	assign load_last = load_idx_reg == 2'(NUM_LOCK - 1);
	assign load_idx_next = load_hit ? load_idx_reg + 2'h1 : load_idx_reg;

	// fetch last byte of each sector
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_raw_reg <= '0;
			load_idx_reg <= 2'h0;
			rd_req_reg <= 1'b0;
			rd_addr_reg <= EXT_LOCK_ADDR;
		end else begin
			rd_req_reg <= (state_reg == FS_LOAD) && !(load_hit && load_last);
			if (load_hit) begin
				lock_raw_reg[load_idx_reg] <= fl_rd_data;
				load_idx_reg <= load_idx_next;
			end
			if (load_idx_next < 2'(NUM_LOCK)) begin
				rd_addr_reg <= LOCK_ADDR[load_idx_next];
			end
		end
	end

	fslc_lock_eval u_eval (
		.lock_bytes(lock_raw_reg),
		.perm(perm.src)
	);

	// flags valid only once the load has ended
	assign perm.ready = (state_reg != FS_LOAD);

	//////////////////////////////////////////////////////////////////////////
	// Command sequencer

	assign cmd_write = avs_write && !wait_reg && (avs_address == REG_CMD) && avs_byteenable[0];
	// lock command only in programming mode
	assign cmd_set_lock = cmd_write && avs_writedata[CMD_SET_CFG_LOCK] && prog_reg
		&& (state_reg == FS_READY);
	assign cmd_erase_all = cmd_write && avs_writedata[CMD_ERASE_ALL] && prog_reg
		&& (state_reg == FS_READY) && !cmd_set_lock;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= FS_LOAD;
		end else begin
			case (state_reg)
				FS_LOAD: begin
					if (load_hit && load_last) begin
						state_reg <= FS_READY;
					end
				end
				FS_READY: begin
					if (cmd_set_lock) begin
						state_reg <= FS_LOCK_WR;
					end else if (cmd_erase_all) begin
						state_reg <= FS_ERASE;
					end
				end
				FS_LOCK_WR, FS_ERASE: begin
					if (fl_op_ack) begin
						state_reg <= FS_READY;
					end
				end
				default: state_reg <= FS_LOAD;
			endcase
		end
	end

	// Writing the lock byte changes flash only; flags stay until the next reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_req_reg <= 1'b0;
			wr_addr_reg <= CFG_LOCK_ADDR;
			wr_data_reg <= LOCK_OFF;
			erase_reg <= 1'b0;
		end else begin
			if (cmd_set_lock) begin
				wr_req_reg <= 1'b1;
				wr_addr_reg <= CFG_LOCK_ADDR;
				wr_data_reg <= LOCK_ON;
			end else if (fl_op_ack) begin
				wr_req_reg <= 1'b0;
			end
			if (cmd_erase_all) begin
				erase_reg <= 1'b1;
			end else if (fl_op_ack) begin
				erase_reg <= 1'b0;
			end
		end
	end

	// power-off request passed to the flash
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_off_reg <= 1'b0;
		end else begin
			pwr_off_reg <= cmd_write && avs_writedata[CMD_POWER_OFF];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Access decisions and debug gate

	fslc_access_check u_check (
		.perm(perm.sink),
		.prog(prog_reg),
		.sector(acc_sector),
		.op(acc_op),
		.from_ext(acc_from_ext),
		.grant(grant_c)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
			grant_reg <= 1'b0;
			debug_reg <= 1'b0;
		end else begin
			done_reg <= acc_valid;
			grant_reg <= acc_valid && grant_c;
			// debug only while user code open
			debug_reg <= dbg_reg && perm.ready && !perm.eff[LK_CODE];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then the answer

	always_comb begin
		rdata_next = 32'h0000_0000;
		case (avs_address)
			REG_STATUS: begin
				rdata_next[ST_READY] = perm.ready;
				rdata_next[ST_EFF_LSB +: 3] = perm.ready ? perm.eff : 3'h0;
				rdata_next[ST_DEBUG_OK] = perm.ready && !perm.eff[LK_CODE];
				rdata_next[ST_PROG] = prog_reg;
				rdata_next[ST_BUSY] = wr_req_reg || erase_reg;
			end
			REG_RAW: rdata_next[23:0] = lock_raw_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			wait_reg <= !((avs_read || avs_write) && wait_reg);
			if (avs_read && wait_reg) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign fl_rd_req = rd_req_reg;
	assign fl_rd_addr = rd_addr_reg;
	assign fl_wr_req = wr_req_reg;
	assign fl_wr_addr = wr_addr_reg;
	assign fl_wr_data = wr_data_reg;
	assign fl_erase_all_req = erase_reg;
	assign flash_power_off_command = pwr_off_reg;
	assign acc_done = done_reg;
	assign acc_grant = grant_reg;
	assign debug_enable = debug_reg;

	//////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_rank_chain_low: assert property (
		perm.eff[LK_CFG] |-> perm.eff[LK_CODE] && perm.eff[LK_EXT])
		else $error("lower lock active without higher one");

	a_exact_value_on: assert property (
		perm.ready && lock_raw_reg[LK_EXT] == LOCK_ON |-> perm.eff[LK_EXT])
		else $error("lock value 0x69 not honoured");

	a_tolerance_far: assert property (
		perm.ready && $countones(lock_raw_reg[LK_EXT] ^ LOCK_ON) > 3 |-> !perm.eff[LK_EXT])
		else $error("lock accepted beyond tolerance");

	a_flags_held: assert property (
		perm.ready && $past(perm.ready) |-> $stable(perm.eff) && $stable(lock_raw_reg))
		else $error("lock flags changed without reset");

	a_debug_refused: assert property (
		perm.ready && perm.eff[LK_CODE] |=> !debug_enable)
		else $error("debug enabled while user code locked");

	a_prog_locked_deny: assert property (
		acc_valid && prog_reg && acc_op == OP_READ && acc_sector == SEC_CODE
		&& perm.eff[LK_CODE] |=> acc_done && !acc_grant)
		else $error("locked sector readable in programming mode");

	a_mass_erase_ok: assert property (
		acc_valid && prog_reg && perm.ready && acc_op == OP_ERASE_ALL |=> acc_grant)
		else $error("mass erase refused");

	a_rom_closed: assert property (
		acc_valid && acc_sector == SEC_ROM && acc_op != OP_ERASE_ALL |=> !acc_grant)
		else $error("firmware sector access granted");

	a_ext_no_write: assert property (
		acc_valid && !prog_reg && acc_sector == SEC_EXT && acc_op != OP_READ |=> !acc_grant)
		else $error("extended sector modified in normal mode");

	a_lock_cmd_data: assert property (
		cmd_set_lock |=> fl_wr_req && fl_wr_data == LOCK_ON && fl_wr_addr == CFG_LOCK_ADDR)
		else $error("lock command wrote wrong byte");

	a_load_reads_all: assert property (
		$rose(perm.ready) |-> load_idx_reg == 2'(NUM_LOCK))
		else $error("ready before all lock bytes read");

	a_bus_answer: assert property (
		(avs_read || avs_write) && wait_reg |=> !wait_reg ##1 wait_reg)
		else $error("bus answer not one cycle late");
endmodule // fslc_top

// ===== verif/fslc_flash_model.sv
// Behavioural flash macro holding the three lock bytes for the lock controller
`timescale 1ns/100ps
module fslc_flash_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic preload,
	input wire logic [23:0] init_bytes,
	input wire logic [3:0] latency,
	input wire logic fl_rd_req,
	input wire logic [fslc_pkg::FL_AW-1:0] fl_rd_addr,
	output logic [7:0] fl_rd_data,
	output logic fl_rd_valid,
	input wire logic fl_wr_req,
	input wire logic [fslc_pkg::FL_AW-1:0] fl_wr_addr,
	input wire logic [7:0] fl_wr_data,
	input wire logic fl_erase_all_req,
	output logic fl_op_ack
);
	import fslc_pkg::*;
	logic [2:0][7:0] lock_mem;
	logic [3:0] wait_cnt;
	function automatic int slot(input logic [15:0] a);
		for (int i = 0; i < NUM_LOCK; i++) begin
			if (a == LOCK_ADDR[i]) return i;
		end
		return NUM_LOCK;
	endfunction
	////////////////////////////////////////
	always_ff @(posedge clk) begin
		fl_rd_valid <= 1'b0;
		fl_op_ack <= 1'b0;
		// Idle data line keeps changing so a stale byte never looks valid
		fl_rd_data <= ~fl_rd_data;
		if (!resetn) begin
			wait_cnt <= 4'h0;
			fl_rd_data <= 8'h5A;
			if (preload) lock_mem <= init_bytes;
		end else if ((fl_rd_req || fl_wr_req || fl_erase_all_req) && !fl_rd_valid && !fl_op_ack) begin
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt >= latency) begin
				wait_cnt <= 4'h0;
				if (fl_rd_req) begin
					fl_rd_valid <= 1'b1;
					fl_rd_data <= (slot(fl_rd_addr) < NUM_LOCK) ? lock_mem[slot(fl_rd_addr)] : 8'hFF;
				end else begin
					fl_op_ack <= 1'b1;
					// lock write; programming only clears bits
					if (fl_wr_req && slot(fl_wr_addr) < NUM_LOCK)
						lock_mem[slot(fl_wr_addr)] <= lock_mem[slot(fl_wr_addr)] & fl_wr_data;
					// whole erase leaves bytes at FF
					if (fl_erase_all_req) lock_mem <= {3{8'hFF}};
				end
			end
		end
	end
endmodule // fslc_flash_model

// ===== verif/test_fslc_top.sv
// Self-checking bench of the flash sector lock controller
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_total++; $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module test_fslc_top;
	import fslc_pkg::*;
	logic clk, resetn, avs_read, avs_write, avs_waitrequest, prog_mode_pin, debug_req_pin;
	logic [7:0] avs_address, fl_rd_data, fl_wr_data;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable, latency;
	logic debug_enable, fl_rd_req, fl_rd_valid, fl_wr_req, fl_erase_all_req, fl_op_ack;
	logic [FL_AW-1:0] fl_rd_addr, fl_wr_addr;
	logic flash_power_off_command, acc_valid, acc_from_ext, acc_done, acc_grant, preload;
	logic [1:0] acc_sector;
	fslc_op_type acc_op;
	logic [23:0] init_bytes, wr_word;
	int err_total = 0;
	int checked = 0;
	int seen [3] = '{0, 0, 0};
	fslc_top fslc_top_i (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .prog_mode_pin, .debug_req_pin,
		.debug_enable, .fl_rd_req, .fl_rd_addr, .fl_rd_data, .fl_rd_valid, .fl_wr_req,
		.fl_wr_addr, .fl_wr_data, .fl_erase_all_req, .fl_op_ack, .flash_power_off_command,
		.acc_valid, .acc_sector, .acc_op, .acc_from_ext, .acc_done, .acc_grant);
	fslc_flash_model fslc_flash_model_i (.clk, .resetn, .preload, .init_bytes, .latency,
		.fl_rd_req, .fl_rd_addr, .fl_rd_data, .fl_rd_valid, .fl_wr_req, .fl_wr_addr,
		.fl_wr_data, .fl_erase_all_req, .fl_op_ack);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Completed flash operations and power-off pulses
	always @(posedge clk) begin
		if (fl_wr_req && fl_op_ack) begin
			seen[0] <= seen[0] + 1;
			wr_word <= {fl_wr_addr, fl_wr_data};
		end
		if (fl_erase_all_req && fl_op_ack) seen[1] <= seen[1] + 1;
		if (flash_power_off_command) seen[2] <= seen[2] + 1;
	end
	////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic timeout();
		err_total++;
		$display("[ERR] wait expected answer seen none");
		finish_test();
	endtask
	task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n = 0;
		@(posedge clk);
		avs_address <= adr;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) timeout();
	endtask
	task automatic await(input int k, input int want);
		int n = 0;
		while (seen[k] < want && n < 60) begin
			@(posedge clk);
			n++;
		end
		if (seen[k] < want) timeout();
	endtask
	task automatic acc(input logic [1:0] sec, input fslc_op_type op, input logic fe, input logic g);
		@(posedge clk);
		acc_valid <= 1'b1;
		acc_sector <= sec;
		acc_op <= op;
		acc_from_ext <= fe;
		@(posedge clk);
		acc_valid <= 1'b0;
		@(posedge clk);
		`CHK("grant", {1'b1, g}, {acc_done, acc_grant})
	endtask
	task automatic chk_st(input logic [23:0] b, input logic pm);
		logic [31:0] rd;
		logic [2:0] en;
		for (int i = 0; i < NUM_LOCK; i++) en[i] = $countones(b[i*8+:8] ^ LOCK_ON) <= LOCK_TOL;
		bus(1'b0, REG_STATUS, 32'h0, rd);
		`CHK("status", {1'b0, pm, ~(en[0] & en[1]), &en, en[0] & en[1], en[0], 1'b1}, rd[6:0])
		`CHK("debug", ~(en[0] & en[1]), debug_enable)
	endtask
	task automatic boot(input logic [23:0] b, input logic pm, input logic pre, input int lat);
		logic [31:0] rd;
		int n = 0;
		@(posedge clk);
		resetn <= 1'b0;
		prog_mode_pin <= pm;
		init_bytes <= b;
		preload <= pre;
		latency <= 4'(lat);
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd = 32'h0;
		while (rd[0] !== 1'b1 && n < 30) begin
			bus(1'b0, REG_STATUS, 32'h0, rd);
			n++;
		end
		if (rd[0] !== 1'b1) timeout();
		chk_st(b, pm);
		bus(1'b0, REG_RAW, 32'h0, rd);
		`CHK("raw", {8'h00, b}, rd)
	endtask
	////////////////////////////////////////
	initial begin
		logic [31:0] rd;
		resetn = 1'b0;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		{prog_mode_pin, acc_valid, acc_sector, acc_from_ext, preload} = '0;
		debug_req_pin = 1'b1;
		acc_op = OP_READ;
		init_bytes = 24'h000000;
		latency = 4'h0;
		boot(24'h000000, 1'b0, 1'b1, 0);
		bus(1'b0, 8'h0C, 32'h0, rd);
		`CHK("unmapped", 32'h0, rd)
		debug_req_pin <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("debug_off", 1'b0, debug_enable)
		debug_req_pin <= 1'b1;
		acc(SEC_ROM, OP_READ, 1'b0, 1'b0);
		acc(SEC_EXT, OP_READ, 1'b0, 1'b1);
		acc(SEC_EXT, OP_WRITE, 1'b1, 1'b0);
		acc(SEC_EXT, OP_ERASE, 1'b0, 1'b0);
		acc(SEC_CFG, OP_ERASE, 1'b0, 1'b1);
		acc(SEC_CODE, OP_ERASE_ALL, 1'b0, 1'b0);
		$display("test unlocked done");
		boot(24'h690069, 1'b1, 1'b1, 3);
		acc(SEC_EXT, OP_READ, 1'b0, 1'b0);
		acc(SEC_CODE, OP_WRITE, 1'b0, 1'b1);
		acc(SEC_CFG, OP_READ, 1'b0, 1'b1);
		acc(SEC_EXT, OP_ERASE_ALL, 1'b0, 1'b1);
		$display("test rank chain done");
		boot(24'h69666E, 1'b0, 1'b1, 1);
		boot(24'h2B1969, 1'b0, 1'b1, 0);
		acc(SEC_CODE, OP_WRITE, 1'b0, 1'b0);
		acc(SEC_CODE, OP_WRITE, 1'b1, 1'b1);
		acc(SEC_CODE, OP_ERASE, 1'b0, 1'b1);
		$display("test tolerance done");
		boot(24'h696969, 1'b1, 1'b1, 0);
		for (int s = 0; s < 3; s++) acc(2'(s), OP_READ, 1'b0, 1'b0);
		acc(SEC_CODE, OP_ERASE, 1'b0, 1'b0);
		acc(SEC_CFG, OP_ERASE_ALL, 1'b0, 1'b1);
		$display("test full lock done");
		boot(24'hFF6969, 1'b1, 1'b1, 2);
		bus(1'b1, REG_CMD, 32'h1, rd);
		await(0, 1);
		`CHK("cfg_lock_wr", {CFG_LOCK_ADDR, LOCK_ON}, wr_word)
		chk_st(24'hFF6969, 1'b1);
		bus(1'b0, REG_RAW, 32'h0, rd);
		`CHK("raw_held", {8'h00, 24'hFF6969}, rd)
		boot(24'h696969, 1'b1, 1'b0, 0);
		bus(1'b1, REG_CMD, 32'h2, rd);
		await(1, 1);
		`CHK("erase_all_ops", 1, seen[1])
		boot(24'hFFFFFF, 1'b1, 1'b0, 1);
		bus(1'b1, REG_CMD, 32'h4, rd);
		await(2, 1);
		repeat (3) @(posedge clk);
		`CHK("power_off_pulses", 1, seen[2])
		prog_mode_pin <= 1'b0;
		repeat (6) @(posedge clk);
		bus(1'b1, REG_CMD, 32'h1, rd);
		repeat (10) @(posedge clk);
		`CHK("normal_mode_lock_cmd", 1, seen[0])
		$display("test commands done");
		finish_test();
	end
endmodule // test_fslc_top
